// ### core/fsp_fifo_serial_port.sv
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"

// Behaviour
// - Status register resets F1H, only init writable
// - Empty flag set after reset, init, drain
// - Full flag set when 32 bytes stored
// - Slave: extra clocks after last byte set overflow
// - Overflow cleared only by init bit or a mid-transfer abort
// - Init bit resets port, clears FIFO, self-clears
// - Eight received bits pushed into FIFO automatically
// - Receive reads return bytes oldest first
// - Written bytes queue, then feed shift register
// - One start moves up to 32 bytes
// - Master drives selected internal clock out
// - Slave shifts on clock from the pin
// - Output on falling edge, sample on rising
// - Bytes shift least significant bit first
// - Start bit begins; completion clears it, flags request
// - Clearing start mid-transfer aborts and initializes
// - Role bit: zero master, one slave
// - Slave ignores clock select and interval bit
// - Completion request, enable, priority, vector 0040
// - Busy bit reports transfer in progress
module fsp_fifo_serial_port
	import fsp_pkg::*;
#(
	parameter int DEPTH = `FSP_FIFO_DEPTH
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        shift_clock_in,
	output logic             shift_clock_out,
	output logic             shift_clock_oe,
	input  wire logic        serial_in,
	output logic             serial_out,
	output logic             completion_irq
);

	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

	// ------------------------------------------------------------
	// Storage and state
	// ------------------------------------------------------------
	logic [7:0]    mem_q [DEPTH];   // Shared byte queue
	logic [PW-1:0] rd_ptr_q;        // Oldest byte
	logic [PW-1:0] wr_ptr_q;        // Next free slot
	logic [PW:0]   cnt_q;           // Bytes held
	logic [2:0]    cksel_q;         // Master clock select
	logic          role_q;          // One selects slave
	logic          ick_q;           // Interval clock enable
	logic          start_q;         // Transfer start bit
	logic          busy_q;          // Transfer in progress
	logic          ovf_q;           // Slave overflow flag
	logic          sdone_q;         // Slave transfer finished
	logic          done_q;          // Completion, one cycle late
	logic          irq_req_q;       // Completion request flag
	logic          irq_en_q;        // Completion enable flag
	logic [1:0]    irq_pri_q;       // Completion priority
	logic          irq_q;           // Gated request pin
	fsp_state_type state_q;         // Engine state
	logic [8:0]    div_q;           // Half period counter
	logic [1:0]    gap_q;           // Interval halves left
	logic [2:0]    bit_q;           // Bit within byte
	logic [PW:0]   left_q;          // Bytes still to move
	logic [7:0]    tx_sh_q;         // Transmit shift register
	logic [7:0]    rx_sh_q;         // Receive shift register
	logic          sclk_q;          // Master clock level
	logic          sclk_oe_q;       // Clock pin drive
	logic          sout_q;          // Serial output level
	logic [2:0]    ck_s_q;          // Clock pin synchroniser
	logic [2:0]    si_s_q;          // Data pin synchroniser
	logic          ck_lvl_q;        // Filtered clock level
	logic          si_lvl_q;        // Filtered data level
	logic [31:0]   prdata_q;        // Read data
	logic          pready_q;        // Ready answer
	logic          pslverr_q;       // Error answer

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	logic setup;      // APB setup cycle
	logic wr;         // Write access phase
	logic rd;         // Read access phase
	logic hit_sctl;   // serial_control selected
	logic hit_fcs;    // fifo_control_status selected
	logic hit_rxd;    // receive_fifo_data selected
	logic hit_txd;    // transmit_fifo_data selected
	logic hit_irq;    // Interrupt register selected
	logic empty;      // FIFO holds nothing
	logic full;       // FIFO holds DEPTH bytes
	logic master;     // Master role
	logic init_p;     // Port initialise pulse
	logic start_p;    // Transfer begins
	logic host_push;  // Software byte in
	logic host_pop;   // Software byte out
	logic eng_push;   // Received byte in
	logic eng_pop;    // Next transmit byte out
	logic push;       // Any push
	logic pop;        // Any pop
	logic tick;       // Master half period elapsed
	logic ck_agree;   // Second and third stages match
	logic ck_rise;    // Slave clock rose
	logic ck_fall;    // Slave clock fell
	logic fall_ev;    // Shift clock falling edge
	logic rise_ev;    // Shift clock rising edge
	logic byte_end;   // Eighth bit sampled
	logic last;       // Final byte of the transfer
	logic done_p;     // Transfer complete
	logic [7:0] rx_byte;  // Assembled byte
	logic [7:0] head;     // Oldest FIFO byte
	logic [8:0] div_top;  // Half period reload

	assign setup    = psel & ~penable;
	assign wr       = psel & penable & pwrite;
	assign rd       = psel & penable & ~pwrite;
	assign hit_sctl = paddr == `FSP_OFF_SCTL;
	assign hit_fcs  = paddr == `FSP_OFF_FCS;
	assign hit_rxd  = paddr == `FSP_OFF_RXD;
	assign hit_txd  = paddr == `FSP_OFF_TXD;
	assign hit_irq  = paddr == `FSP_OFF_IRQ;
	assign empty    = cnt_q == '0;
	assign full     = cnt_q == FULL_CNT;
	assign master   = ~role_q;
	assign head     = mem_q[rd_ptr_q];

	// Init bit, or clearing start while busy, both initialise
	assign init_p = (wr & hit_fcs & pwdata[`FSP_FC_INIT])
		| (wr & hit_sctl & ~pwdata[`FSP_SC_START] & busy_q);

	assign start_p = wr & hit_sctl & pwdata[`FSP_SC_START]
		& ~busy_q & ~start_q;

	// Data accesses while busy are dropped to protect the shift
	assign host_push = wr & hit_txd & ~busy_q & ~full;
	assign host_pop  = rd & hit_rxd & ~busy_q & ~empty;

	// ------------------------------------------------------------
	// Edge sources for the shift clock
	// ------------------------------------------------------------
	assign div_top  = (9'd2 << cksel_q) - 9'd1;
	assign tick     = master & (div_q == '0);
	assign ck_agree = ck_s_q[1] == ck_s_q[2];
	assign ck_rise  = ck_agree & ck_s_q[1] & ~ck_lvl_q;
	assign ck_fall  = ck_agree & ~ck_s_q[1] & ck_lvl_q;

	// Slave uses the pin, master its own divider
	assign fall_ev = (state_q == fsp_st_run)
		& (master ? (tick & sclk_q) : ck_fall);
	assign rise_ev = (state_q == fsp_st_run)
		& (master ? (tick & ~sclk_q) : ck_rise);

	assign byte_end = rise_ev & (bit_q == 3'd7);
	assign last     = left_q == (PW+1)'(1);
	assign rx_byte  = {si_lvl_q, rx_sh_q[7:1]};
	assign eng_push = byte_end;
	assign eng_pop  = (start_p & ~empty)
		| (byte_end & ~last);
	assign done_p   = (start_p & empty) | (byte_end & last);
	assign push     = host_push | eng_push;
	assign pop      = host_pop | eng_pop;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Three stages; a level counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_s_q   <= 3'h7;
			si_s_q   <= 3'h7;
			ck_lvl_q <= 1'b1;
			si_lvl_q <= 1'b1;
		end else begin
			ck_s_q <= {ck_s_q[1:0], shift_clock_in};
			si_s_q <= {si_s_q[1:0], serial_in};
			if (ck_agree) begin
				ck_lvl_q <= ck_s_q[1];
			end
			if (si_s_q[1] == si_s_q[2]) begin
				si_lvl_q <= si_s_q[1];
			end
		end
	end

	// ------------------------------------------------------------
	// FIFO storage and pointers
	// ------------------------------------------------------------
	// Engine pushes take the slot; software cannot push while busy
	always_ff @(posedge pclk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= eng_push ? rx_byte : pwdata[7:0];
		end
	end

	// One queue serves both ways, so oldest-first holds for reads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ptr_q <= '0;
			wr_ptr_q <= '0;
			cnt_q    <= '0;
		end else if (init_p) begin
			rd_ptr_q <= '0;
			wr_ptr_q <= '0;
			cnt_q    <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= PW'(wr_ptr_q + 1'b1);
			end
			if (pop) begin
				rd_ptr_q <= PW'(rd_ptr_q + 1'b1);
			end
			case ({push, pop})
				2'b10:   cnt_q <= (PW+1)'(cnt_q + 1'b1);
				2'b01:   cnt_q <= (PW+1)'(cnt_q - 1'b1);
				default: cnt_q <= cnt_q;
			endcase
		end
	end

	// ------------------------------------------------------------
	// serial_control
	// ------------------------------------------------------------
	// Mode bits are locked while busy so a live transfer stays sane
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cksel_q <= 3'h0;
			role_q  <= 1'b0;
			ick_q   <= 1'b0;
			start_q <= 1'b0;
		end else begin
			if (wr & hit_sctl & ~busy_q) begin
				cksel_q <= pwdata[`FSP_SC_CKHI:`FSP_SC_CKLO];
				role_q  <= pwdata[`FSP_SC_ROLE];
				ick_q   <= pwdata[`FSP_SC_ICK];
			end
			if (init_p) begin
				start_q <= 1'b0;
			end else if (start_p) begin
				start_q <= 1'b1;
			end
			if (done_p) begin
				start_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Busy flag and slave overflow
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q  <= 1'b0;
			sdone_q <= 1'b0;
			ovf_q   <= 1'b0;
		end else begin
			if (init_p | done_p) begin
				busy_q <= 1'b0;
			end else if (start_p) begin
				busy_q <= 1'b1;
			end
			if (init_p | start_p) begin
				sdone_q <= 1'b0;
			end
			if (done_p & role_q) begin
				sdone_q <= 1'b1;
			end
			// Set wins over the init clear in the same cycle
			if (sdone_q & role_q & ck_fall) begin
				ovf_q <= 1'b1;
			end else if (init_p) begin
				ovf_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Transfer engine
	// ------------------------------------------------------------
	// Clock rests high; a fall drives a bit, a rise samples one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= fsp_st_idle;
			div_q   <= '0;
			gap_q   <= '0;
			bit_q   <= '0;
			left_q  <= '0;
			tx_sh_q <= '0;
			rx_sh_q <= '0;
			sclk_q  <= 1'b1;
			sout_q  <= 1'b1;
		end else if (init_p) begin
			state_q <= fsp_st_idle;
			sclk_q  <= 1'b1;
			bit_q   <= '0;
		end else begin
			case (state_q)
				fsp_st_idle: begin
					sclk_q <= 1'b1;
					if (start_p & ~empty) begin
						state_q <= fsp_st_run;
						tx_sh_q <= head;
						left_q  <= cnt_q;
						div_q   <= div_top;
						bit_q   <= '0;
					end
				end
				fsp_st_run: begin
					if (master) begin
						div_q <= tick ? div_top : 9'(div_q - 1'b1);
						if (tick) begin
							sclk_q <= ~sclk_q;
						end
					end
					if (fall_ev) begin
						sout_q  <= tx_sh_q[0];
						tx_sh_q <= {1'b0, tx_sh_q[7:1]};
					end
					if (rise_ev) begin
						rx_sh_q <= rx_byte;
						bit_q   <= bit_q + 3'd1;
					end
					if (byte_end) begin
						left_q <= (PW+1)'(left_q - 1'b1);
						if (last) begin
							state_q <= fsp_st_idle;
						end else begin
							tx_sh_q <= head;
							// Interval only applies to master
							if (ick_q & master) begin
								state_q <= fsp_st_gap;
								gap_q   <= `FSP_GAP_HALVES;
							end
						end
					end
				end
				fsp_st_gap: begin
					div_q <= tick ? div_top : 9'(div_q - 1'b1);
					if (tick) begin
						gap_q <= gap_q - 2'd1;
						if (gap_q == 2'd1) begin
							state_q <= fsp_st_run;
						end
					end
				end
				default: state_q <= fsp_st_idle;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	// Slave never drives the clock pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_oe_q <= 1'b0;
		end else begin
			sclk_oe_q <= master;
		end
	end

	// ------------------------------------------------------------
	// Completion request, enable and priority
	// ------------------------------------------------------------
	// Request rises one cycle after completion; set beats clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q    <= 1'b0;
			irq_req_q <= 1'b0;
			irq_en_q  <= 1'b0;
			irq_pri_q <= '0;
			irq_q     <= 1'b0;
		end else begin
			done_q <= done_p;
			if (done_q) begin
				irq_req_q <= 1'b1;
			end else if (wr & hit_irq) begin
				irq_req_q <= pwdata[`FSP_IQ_REQ];
			end
			if (wr & hit_irq) begin
				irq_en_q  <= pwdata[`FSP_IQ_EN];
				irq_pri_q <= pwdata[`FSP_IQ_PHI:`FSP_IQ_PLO];
			end
			irq_q <= irq_req_q & irq_en_q;
		end
	end

	// ------------------------------------------------------------
	// APB answer
	// ------------------------------------------------------------
	// Read data is captured in the setup cycle, zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= 1'b1;
			if (setup) begin
				pslverr_q <= ~(hit_sctl | hit_fcs | hit_rxd
					| hit_txd | hit_irq);
				prdata_q <= '0;
				if (~pwrite & hit_sctl) begin
					prdata_q[7:0] <= {1'b1, busy_q, ick_q, start_q,
						role_q, cksel_q};
				end
				if (~pwrite & hit_fcs) begin
					prdata_q[7:0] <= {4'hf, 1'b0, ovf_q,
						full, empty};
				end
				if (~pwrite & hit_rxd) begin
					prdata_q[7:0] <= head;
				end
				if (~pwrite & hit_irq) begin
					prdata_q <= {`FSP_IRQ_VECTOR, 12'h000,
						irq_pri_q, irq_en_q, irq_req_q};
				end
			end
		end
	end

	assign prdata          = prdata_q;
	assign pready          = pready_q;
	assign pslverr         = pslverr_q;
	assign shift_clock_out = sclk_q;
	assign shift_clock_oe  = sclk_oe_q;
	assign serial_out      = sout_q;
	assign completion_irq  = irq_q;

endmodule : fsp_fifo_serial_port

`default_nettype wire

// ### core/fsp_unused_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### shared/fsp_cfg.svh
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets on the APB side
// ----------------------------------------------------------------
`define FSP_OFF_SCTL   12'h000
`define FSP_OFF_FCS    12'h004
`define FSP_OFF_RXD    12'h008
`define FSP_OFF_TXD    12'h00c
`define FSP_OFF_IRQ    12'h010

// ----------------------------------------------------------------
// serial_control fields and reset value
// ----------------------------------------------------------------
`define FSP_SCTL_RST   8'h80
`define FSP_SC_CKLO    0
`define FSP_SC_CKHI    2
`define FSP_SC_ROLE    3
`define FSP_SC_START   4
`define FSP_SC_ICK     5
`define FSP_SC_BUSY    6

// ----------------------------------------------------------------
// fifo_control_status fields and reset value
// ----------------------------------------------------------------
`define FSP_FCS_RST    8'hf1
`define FSP_FC_EMPTY   0
`define FSP_FC_FULL    1
`define FSP_FC_OVF     2
`define FSP_FC_INIT    3

// ----------------------------------------------------------------
// Completion interrupt register fields
// ----------------------------------------------------------------
`define FSP_IQ_REQ     0
`define FSP_IQ_EN      1
`define FSP_IQ_PLO     2
`define FSP_IQ_PHI     3
`define FSP_IRQ_VECTOR 16'h0040

// ----------------------------------------------------------------
// Sizes and timing counts
// ----------------------------------------------------------------
`define FSP_FIFO_DEPTH 32
`define FSP_GAP_HALVES 2'd2

`endif

// ### shared/fsp_pkg.sv
package fsp_pkg;

	// ------------------------------------------------------------
	// Transfer engine states, Gray coded idle -> run -> gap
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		fsp_st_idle = 2'b00,
		fsp_st_run  = 2'b01,
		fsp_st_gap  = 2'b11
	} fsp_state_type;

endpackage : fsp_pkg

// ### sim/fsp_ext_device.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// External clocked serial device on the far side of the link
// ----------------------------------------------------------------
module fsp_ext_device (
	input  wire logic pin_clk,
	input  wire logic dev_out,
	output logic      dev_in,
	output logic      gen_clk
);
	logic [7:0] tx_mem [32];     // Bytes it sends, oldest first
	logic [7:0] rx_q [$];        // Bytes it heard from the port
	logic [7:0] sh = 8'h00;      // Receive shifter
	int         tx_idx = 0;      // Byte being sent
	int         bit_cnt = 0;     // Bit within the byte

	// Clock idles high outside frames
	initial begin
		gen_clk = 1'b1;
		dev_in  = 1'b1;
	end

	// Changes data on the falling edge, low bit first
	always @(negedge pin_clk) begin
		dev_in <= tx_mem[tx_idx % 32][bit_cnt];
	end

	// Samples on the rising edge; eight bits close a byte
	always @(posedge pin_clk) begin
		sh = {dev_out, sh[7:1]};
		if (bit_cnt == 7) begin
			rx_q.push_back(sh);
			bit_cnt = 0;
			tx_idx++;
		end else begin
			bit_cnt++;
		end
	end

	// Burst of pulses at 160 ns when this side owns the clock
	task automatic clock_bits(input int n);
		#7;
		repeat (n) begin
			#80 gen_clk = 1'b0;
			#80 gen_clk = 1'b1;
		end
	endtask : clock_bits
endmodule : fsp_ext_device
`default_nettype wire

// ### sim/fsp_fifo_serial_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"

// ----------------------------------------------------------------
// Port checker: register reads and shift clock pins
// ----------------------------------------------------------------
module fsp_fifo_serial_port_sva #(
	parameter int DEPTH = `FSP_FIFO_DEPTH
)(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        shift_clock_in,
	input wire logic        shift_clock_out,
	input wire logic        shift_clock_oe,
	input wire logic        serial_in,
	input wire logic        serial_out,
	input wire logic        completion_irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	wire logic rd_acc;  // Read access cycle on the register bus
	assign rd_acc = psel && penable && !pwrite;

	// Zero wait states, so no access may stall
	property p_pready;
		psel && penable |-> pready;
	endproperty
	a_pready: assert property (p_pready) else $error("no pready");

	// Anything past the last register is refused
	property p_slverr;
		psel && penable && paddr > `FSP_OFF_IRQ |-> pslverr;
	endproperty
	a_slverr: assert property (p_slverr) else $error("no slverr");

	// Control byte: top bit always reads one
	property p_sctl_rd;
		rd_acc && paddr == `FSP_OFF_SCTL |-> prdata[31:7] == 25'h1;
	endproperty
	a_sctl_rd: assert property (p_sctl_rd) else $error("sctl read");

	// Status: top nibble ones, init reads zero, never empty and full
	property p_fcs_rd;
		rd_acc && paddr == `FSP_OFF_FCS
			|-> prdata[31:3] == 29'h1e && !(prdata[0] && prdata[1]);
	endproperty
	a_fcs_rd: assert property (p_fcs_rd) else $error("fcs read");

	// Vector field is constant
	property p_irq_vec;
		rd_acc && paddr == `FSP_OFF_IRQ
			|-> prdata[31:16] == `FSP_IRQ_VECTOR;
	endproperty
	a_irq_vec: assert property (p_irq_vec) else $error("vector");

	// Shortest master half period is two cycles
	property p_clk_low;
		$fell(shift_clock_out) |-> !shift_clock_out [*2];
	endproperty
	a_clk_low: assert property (p_clk_low) else $error("short low");

	// Master data moves only while the shift clock is low
	property p_sout_edge;
		shift_clock_oe && $stable(shift_clock_oe) && $changed(serial_out)
			|-> !shift_clock_out;
	endproperty
	a_sout_edge: assert property (p_sout_edge) else $error("sout");

	// Slave role never makes a clock of its own
	property p_slave_idle;
		!shift_clock_oe |-> shift_clock_out;
	endproperty
	a_slave_idle: assert property (p_slave_idle) else $error("clk");
endmodule : fsp_fifo_serial_port_sva

bind fsp_fifo_serial_port fsp_fifo_serial_port_sva #(.DEPTH(DEPTH)) u_sva (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.shift_clock_in(shift_clock_in), .shift_clock_out(shift_clock_out),
	.shift_clock_oe(shift_clock_oe), .serial_in(serial_in),
	.serial_out(serial_out), .completion_irq(completion_irq)
);
`default_nettype wire

// ### sim/test_fifo_sync_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"

module test_fifo_sync_serial_port;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, shift_clock_out, shift_clock_oe;
	logic        serial_out, completion_irq, dev_in, gen_clk;
	wire logic   pin_clk;        // Clock pin, driven by its owner
	logic [7:0]  lfsr = 8'h34;   // Fixed seed
	int          num_errors = 0;
	int          checks_done = 0;

	always #10 pclk = ~pclk;
	assign pin_clk = shift_clock_oe ? shift_clock_out : gen_clk;

	fsp_fifo_serial_port DUT (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.shift_clock_in(pin_clk), .shift_clock_out(shift_clock_out),
		.shift_clock_oe(shift_clock_oe), .serial_in(dev_in),
		.serial_out(serial_out), .completion_irq(completion_irq)
	);

	fsp_ext_device P (
		.pin_clk(pin_clk), .dev_out(serial_out), .dev_in(dev_in),
		.gen_clk(gen_clk)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction : rnd

	// Status byte expected for a fill level and overflow state
	function automatic logic [31:0] fcs_exp(input int n, input logic ovf);
		return {24'h0, 4'hf, 1'b0, ovf, n == 32, n == 0};
	endfunction : fcs_exp

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One APB transfer; waits for pready, the watchdog bounds the wait
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rchk(input logic [11:0] a, input logic [31:0] x,
		input string nm);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, r, x);
	endtask : rchk

	// Polls busy; the limit stands in for a hang
	task automatic wait_idle();
		logic [31:0] v;
		logic        e;
		int          n;
		n = 0;
		do begin
			apb(1'b0, `FSP_OFF_SCTL, 32'h0, v, e);
			n++;
		end while (v[`FSP_SC_BUSY] !== 1'b0 && n < 8000);
		if (n == 8000) begin
			num_errors++;
			stop_test();
		end
	endtask : wait_idle

	task automatic new_frame();
		P.bit_cnt = 0;
		P.tx_idx  = 0;
		P.rx_q.delete();
	endtask : new_frame

	task automatic stop_test();
		if (num_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		logic [31:0] v, r;
		logic        e;
		logic [7:0]  tx [32];
		logic [7:0]  ck;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rchk(`FSP_OFF_SCTL, {24'h0, `FSP_SCTL_RST}, "sctl_rst");
		rchk(`FSP_OFF_FCS, {24'h0, `FSP_FCS_RST}, "fcs_rst");
		wr(`FSP_OFF_FCS, 32'h0000_00f7);
		rchk(`FSP_OFF_FCS, fcs_exp(0, 1'b0), "fcs_ro");
		apb(1'b0, 12'h014, 32'h0, r, e);
		chk("unmapped", {31'h0, e}, 32'h1);
		// Master: full FIFO in one go, random clock select and gap
		new_frame();
		for (int i = 0; i < 32; i++) begin
			tx[i] = rnd();
			P.tx_mem[i] = rnd();
			wr(`FSP_OFF_TXD, {24'h0, tx[i]});
		end
		wr(`FSP_OFF_TXD, 32'h0000_00a5);
		rchk(`FSP_OFF_FCS, fcs_exp(32, 1'b0), "fcs_full");
		wr(`FSP_OFF_IRQ, 32'h0000_0002);
		ck = rnd();
		// Clock select 3 or 4 keeps the master bit rate at a safe speed
		v = {24'h0, 2'b10, ck[1], 1'b1, 1'b0, ck[0], ~ck[0], ~ck[0]};
		wr(`FSP_OFF_SCTL, v);
		apb(1'b0, `FSP_OFF_SCTL, 32'h0, r, e);
		chk("busy", {31'h0, r[`FSP_SC_BUSY]}, 32'h1);
		wait_idle();
		rchk(`FSP_OFF_SCTL, v & 32'hffff_ffef, "sctl_done");
		rchk(`FSP_OFF_IRQ, 32'h0040_0003, "irq_req");
		chk("irq_pin", {31'h0, completion_irq}, 32'h1);
		chk("ext_cnt", P.rx_q.size(), 32'd32);
		for (int i = 0; i < 32; i++)
			chk("ext_rx", {24'h0, P.rx_q[i]}, {24'h0, tx[i]});
		for (int i = 0; i < 32; i++)
			rchk(`FSP_OFF_RXD, {24'h0, P.tx_mem[i]}, "rx");
		rchk(`FSP_OFF_FCS, fcs_exp(0, 1'b0), "fcs_drained");
		wr(`FSP_OFF_IRQ, 32'h0000_000e);
		rchk(`FSP_OFF_IRQ, 32'h0040_000e, "irq_clr");
		chk("irq_low", {31'h0, completion_irq}, 32'h0);
		// Slave: clock select and gap bit set but must not matter
		wr(`FSP_OFF_SCTL, 32'h0000_002f);
		new_frame();
		for (int i = 0; i < 3; i++) begin
			P.tx_mem[i] = rnd();
			wr(`FSP_OFF_TXD, 32'h0);
		end
		wr(`FSP_OFF_SCTL, 32'h0000_003f);
		P.clock_bits(24);
		wait_idle();
		for (int i = 0; i < 3; i++)
			rchk(`FSP_OFF_RXD, {24'h0, P.tx_mem[i]}, "slv_rx");
		P.clock_bits(1);
		repeat (8) @(posedge pclk);
		rchk(`FSP_OFF_FCS, fcs_exp(0, 1'b1), "ovf_set");
		wr(`FSP_OFF_FCS, 32'h0000_0008);
		rchk(`FSP_OFF_FCS, fcs_exp(0, 1'b0), "ovf_clr");
		// Slave abort mid byte
		wr(`FSP_OFF_SCTL, 32'h0000_0008);
		new_frame();
		wr(`FSP_OFF_TXD, 32'h0000_003c);
		wr(`FSP_OFF_TXD, 32'h0000_00c3);
		wr(`FSP_OFF_SCTL, 32'h0000_0018);
		P.clock_bits(4);
		wr(`FSP_OFF_SCTL, 32'h0000_0008);
		rchk(`FSP_OFF_SCTL, 32'h0000_0088, "abort_idle");
		rchk(`FSP_OFF_FCS, fcs_exp(0, 1'b0), "abort_fifo");
		stop_test();
	end

	// Watchdog well past the expected run length
	initial begin
		#1000000;
		num_errors++;
		stop_test();
	end
endmodule : test_fifo_sync_serial_port
`default_nettype wire
